// *** core/evt_pkg.sv ***
// Purpose: shared constants for the event interrupt logic
// Assumes: 16-bit management registers, 5-bit register address
// Notes: bit positions name each event source in enable and pending
package evt_pkg;

    // ----------------------------------------
    // bus shape
    // ----------------------------------------
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h11;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_PENDING = 5'h13;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 5'h14;

    // ----------------------------------------
    // event bit positions, shared by enable and pending
    // ----------------------------------------
    localparam int NEG_ERROR_BIT = 15;
    localparam int RATE_CHANGE_BIT = 14;
    localparam int DUPLEX_CHANGE_BIT = 13;
    localparam int PAGE_RECEIVED_BIT = 12;
    localparam int NEG_DONE_BIT = 11;
    localparam int LINK_CHANGE_BIT = 10;
    localparam int FALSE_CARRIER_BIT = 8;
    localparam int CROSSOVER_CHANGE_BIT = 6;
    localparam int DOWNSHIFT_BIT = 5;
    localparam int DOZE_CHANGE_BIT = 4;
    localparam int WAKE_PACKET_BIT = 3;
    localparam int MAC_IF_ERROR_BIT = 2;
    localparam int INVERSION_CHANGE_BIT = 1;
    localparam int JABBER_EVENT_BIT = 0;

    // reserved bits 9 and 7 stay out of the mask
    localparam logic [DATA_W-1:0] EVENT_MASK =
        (16'h0001 << NEG_ERROR_BIT) | (16'h0001 << RATE_CHANGE_BIT) |
        (16'h0001 << DUPLEX_CHANGE_BIT) | (16'h0001 << PAGE_RECEIVED_BIT) |
        (16'h0001 << NEG_DONE_BIT) | (16'h0001 << LINK_CHANGE_BIT) |
        (16'h0001 << FALSE_CARRIER_BIT) | (16'h0001 << CROSSOVER_CHANGE_BIT) |
        (16'h0001 << DOWNSHIFT_BIT) | (16'h0001 << DOZE_CHANGE_BIT) |
        (16'h0001 << WAKE_PACKET_BIT) | (16'h0001 << MAC_IF_ERROR_BIT) |
        (16'h0001 << INVERSION_CHANGE_BIT) | (16'h0001 << JABBER_EVENT_BIT);

    // ----------------------------------------
    // status summary and config fields
    // ----------------------------------------
    localparam int STATUS_INV_POL_BIT = 1;
    localparam int STATUS_JABBER_BIT = 0;
    localparam int CFG_IRQ_POL_BIT = 13;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [DATA_W-1:0] ENABLE_RST = 16'h0000;
    localparam logic [DATA_W-1:0] PENDING_RST = 16'h0000;
    localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;
    localparam logic IRQ_POL_RST = 1'b1;

    // decoded register select
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_STATUS,
        SEL_ENABLE,
        SEL_PENDING,
        SEL_CONFIG
    } reg_sel_t;

endpackage : evt_pkg

// *** core/event_latch.sv ***
// Purpose: bank of latched-high event bits, cleared per bit
// Assumes: set and clear arrive in the same clock domain
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
module event_latch
    import evt_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter logic [WIDTH-1:0] MASK = EVENT_MASK,
    parameter logic [WIDTH-1:0] RST_VAL = PENDING_RST
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] set_bits,
    input wire logic [WIDTH-1:0] clr_bits,
    output logic [WIDTH-1:0] pend_q
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] pend;
    } latch_state_t;

    latch_state_t st_q;
    latch_state_t st_d;
    logic [WIDTH-1:0] nxt_bits;

    genvar b;
    generate
        for (b = 0; b < WIDTH; b++)
        begin : g_bit
            if (MASK[b])
            begin : g_live
                // an event in the clearing cycle survives
                assign nxt_bits[b] = set_bits[b] | (st_q.pend[b] & ~clr_bits[b]);
            end
            else
            begin : g_resv
                assign nxt_bits[b] = 1'b0;
            end
        end
    endgenerate

    always_comb
    begin
        st_d = st_q;
        st_d.pend = nxt_bits;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_q <= '{pend: RST_VAL};
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    assign pend_q = st_q.pend;

endmodule : event_latch

// *** core/phy_event_interrupt_logic.sv ***
// Purpose: event enable, latched pending, status summary and interrupt pin
// Assumes: one clock, event inputs are one-cycle pulses synchronous to clk
// Notes: read data appear one cycle after the read strobe, never stall
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps

module phy_event_interrupt_logic
    import evt_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rdata,
    input wire logic inv_polarity,
    input wire logic basic_mode_jabber,
    input wire logic [DATA_W-1:0] event_in,
    output logic irq_out
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] enable;
        logic irq_pol;
        logic [DATA_W-1:0] rdata;
        logic irq;
    } ctl_state_t;

    localparam ctl_state_t CTL_RST = '{
        enable: ENABLE_RST,
        irq_pol: IRQ_POL_RST,
        rdata: RDATA_RST,
        // inactive pin level equals the polarity bit, so reset leaves it idle
        irq: IRQ_POL_RST
    };

    ctl_state_t st_q;
    ctl_state_t st_d;
    reg_sel_t sel;
    logic [DATA_W-1:0] pend_q;
    logic [DATA_W-1:0] clr_bits;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] config_word;
    logic irq_active;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    always_comb
    begin
        case (addr)
            ADDR_STATUS: sel = SEL_STATUS;
            ADDR_ENABLE: sel = SEL_ENABLE;
            ADDR_PENDING: sel = SEL_PENDING;
            ADDR_CONFIG: sel = SEL_CONFIG;
            default: sel = SEL_NONE;
        endcase
    end

    // ----------------------------------------
    // read words
    // ----------------------------------------
    // other summary fields belong to blocks outside this one, read zero
    always_comb
    begin
        status_word = '0;
        status_word[STATUS_INV_POL_BIT] = inv_polarity;
        // jabber passes through at any speed; software qualifies it by rate
        status_word[STATUS_JABBER_BIT] = basic_mode_jabber;
        config_word = '0;
        config_word[CFG_IRQ_POL_BIT] = st_q.irq_pol;
    end

    // ----------------------------------------
    // pending bank
    // ----------------------------------------
    // clear exactly the word handed back, nothing that arrives meanwhile
    assign clr_bits = (rd_stb && sel == SEL_PENDING) ? pend_q : '0;

    event_latch #(
        .WIDTH(DATA_W),
        .MASK(EVENT_MASK),
        .RST_VAL(PENDING_RST)
    ) u_pending (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .set_bits(event_in & EVENT_MASK),
        .clr_bits(clr_bits),
        .pend_q(pend_q)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    assign irq_active = |(pend_q & st_q.enable);

    always_comb
    begin
        st_d = st_q;
        st_d.rdata = '0;
        if (wr_stb)
        begin
            case (sel)
                SEL_ENABLE: st_d.enable = wdata & EVENT_MASK;
                SEL_CONFIG: st_d.irq_pol = wdata[CFG_IRQ_POL_BIT];
                default: st_d.enable = st_q.enable;
            endcase
        end
        if (rd_stb)
        begin
            case (sel)
                SEL_STATUS: st_d.rdata = status_word;
                SEL_ENABLE: st_d.rdata = st_q.enable;
                SEL_PENDING: st_d.rdata = pend_q;
                SEL_CONFIG: st_d.rdata = config_word;
                default: st_d.rdata = '0;
            endcase
        end
        // pin level costs one cycle of lag, buys a glitch-free output
        st_d.irq = st_q.irq_pol ? ~irq_active : irq_active;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_q <= CTL_RST;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign irq_out = st_q.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_status_read;
        ce && rd_stb && sel == SEL_STATUS;
    endsequence

    sequence s_pending_read;
        ce && rd_stb && sel == SEL_PENDING;
    endsequence

    sequence s_enable_write;
        ce && wr_stb && sel == SEL_ENABLE;
    endsequence

    a_polarity_status:
    assert property (s_status_read |=>
        rdata[STATUS_INV_POL_BIT] == $past(inv_polarity))
    else $error("polarity status bit wrong");

    a_jabber_mirror:
    assert property (s_status_read |=>
        rdata[STATUS_JABBER_BIT] == $past(basic_mode_jabber))
    else $error("jabber status bit does not mirror input");

    a_jabber_no_clear:
    assert property ((s_status_read and basic_mode_jabber) ##1
        (s_status_read and basic_mode_jabber) |=> rdata[STATUS_JABBER_BIT])
    else $error("status read cleared jabber");

    a_irq_pin_level:
    assert property (ce |=>
        irq_out == ($past(st_q.irq_pol) ^ $past(irq_active)))
    else $error("interrupt pin disagrees with enabled pending");

    a_disabled_quiet:
    assert property (ce && st_q.enable == '0 |=> irq_out == $past(st_q.irq_pol))
    else $error("interrupt asserted with all sources disabled");

    a_event_latches:
    assert property (ce && (event_in & EVENT_MASK) != '0 |=>
        (pend_q & $past(event_in & EVENT_MASK)) == $past(event_in & EVENT_MASK))
    else $error("event not latched in pending");

    a_pending_holds:
    assert property (ce && !(rd_stb && sel == SEL_PENDING) && event_in == '0 |=>
        pend_q == $past(pend_q))
    else $error("pending changed without read or event");

    a_read_returns:
    assert property (s_pending_read |=> rdata == $past(pend_q))
    else $error("pending read returned wrong word");

    a_read_clears:
    assert property (s_pending_read and event_in == '0 |=> pend_q == '0)
    else $error("pending read left bits set");

    a_set_beats_clear:
    assert property (s_pending_read and (event_in & EVENT_MASK) != '0 |=>
        pend_q == $past(event_in & EVENT_MASK))
    else $error("event lost in clearing cycle");

    a_enable_write:
    assert property (s_enable_write ##1 (ce && !wr_stb) [*2] |->
        st_q.enable == $past(wdata & EVENT_MASK, 2))
    else $error("enable register did not take write");

    a_reserved_zero:
    assert property ((st_q.enable & ~EVENT_MASK) == '0 && (pend_q & ~EVENT_MASK) == '0)
    else $error("reserved bit set");

    a_reset_state:
    assert property ($rose(nrst) |-> st_q.enable == ENABLE_RST &&
        irq_out == IRQ_POL_RST && pend_q == PENDING_RST)
    else $error("reset values wrong");

    // ----------------------------------------
    // register readback and freeze checks
    // ----------------------------------------
    sequence s_enable_read;
        ce && rd_stb && sel == SEL_ENABLE;
    endsequence

    sequence s_config_read;
        ce && rd_stb && sel == SEL_CONFIG;
    endsequence

    sequence s_config_write;
        ce && wr_stb && sel == SEL_CONFIG;
    endsequence

    a_enable_readback:
    assert property (s_enable_read |=> rdata == $past(st_q.enable))
    else $error("enable read returned wrong word");

    a_enable_holds:
    assert property (ce && !(wr_stb && sel == SEL_ENABLE) |=>
        st_q.enable == $past(st_q.enable))
    else $error("enable changed without a write");

    a_config_readback:
    assert property (s_config_read |=>
        rdata[CFG_IRQ_POL_BIT] == $past(st_q.irq_pol))
    else $error("config read returned wrong polarity");

    a_config_write:
    assert property (s_config_write |=>
        st_q.irq_pol == $past(wdata[CFG_IRQ_POL_BIT]))
    else $error("polarity write not taken");

    a_status_upper_zero:
    assert property (s_status_read |=>
        rdata[DATA_W-1:STATUS_INV_POL_BIT+1] == '0)
    else $error("unimplemented status bits not zero");

    a_rdata_idle:
    assert property (ce && !rd_stb |=> rdata == '0)
    else $error("read data present without a read");

    a_pending_no_write:
    assert property (ce && wr_stb && sel == SEL_PENDING && event_in == '0 |=>
        pend_q == $past(pend_q))
    else $error("write disturbed pending bits");

    // a cleared bank must drop the pin back to its idle level
    a_irq_drops:
    assert property ((s_pending_read and event_in == '0) ##1 ce |=>
        irq_out == $past(st_q.irq_pol))
    else $error("interrupt pin stuck after clearing read");

    // a low enable stalls everything, strobes and events included
    a_freeze_state:
    assert property (!ce |=> st_q == $past(st_q) && pend_q == $past(pend_q))
    else $error("state moved while clock enable low");

    a_status_jabber_live:
    assert property (s_status_read ##1 s_status_read |=>
        rdata[STATUS_JABBER_BIT] == $past(basic_mode_jabber))
    else $error("second status read lost jabber");

endmodule : phy_event_interrupt_logic

// *** tb/host_model.sv ***
// Purpose: host side of the register port
// Assumes: every task is entered just after a rising edge
// Notes: idle inverts the address and data lines and drops both strobes, so no stale value looks valid
`timescale 1ns/1ps
module host_model
    import evt_pkg::*;
(
    input wire logic clk,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic wr_stb,
    output logic rd_stb
);
    initial
    begin
        addr = '0;
        wdata = '0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    // strobes left high so back-to-back calls never assign twice
    task automatic put(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= w;
        rd_stb <= !w;
        @(posedge clk);
    endtask : put

    task automatic idle();
        addr <= ~addr;
        wdata <= ~wdata;
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        @(posedge clk);
    endtask : idle
endmodule : host_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the event interrupt logic
// Assumes: read data checked one edge after the read edge
// Notes: events are driven by the bench, registers by host_model
`timescale 1ns/1ps
module tb_top
    import evt_pkg::*;
;
    localparam logic [15:0] EV = 16'hFD7F;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic inv_polarity = 1'b0;
    logic basic_mode_jabber = 1'b0;
    logic [DATA_W-1:0] event_in = '0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [DATA_W-1:0] rdata;
    logic irq_out;
    logic rd_q = 1'b0;
    logic [15:0] lfsr = 16'h82FF;
    logic [DATA_W-1:0] exp_q[$];
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    phy_event_interrupt_logic phy_event_interrupt_logic_inst (.clk, .nrst, .ce, .addr,
        .wdata, .wr_stb, .rd_stb, .rdata, .inv_polarity, .basic_mode_jabber, .event_in,
        .irq_out);
    host_model host_model_inst (.clk, .addr, .wdata, .wr_stb, .rd_stb);

    // ----
    // helpers
    // ----
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk16

    // pin sampled 1 ns after the edge, once its update has landed
    task automatic chk_irq(input logic exp);
        #1;
        comparisons++;
        if (irq_out !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, irq_out, exp);
        end
    endtask : chk_irq

    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        host_model_inst.put(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        exp_q.push_back(exp);
        host_model_inst.put(1'b0, a, lfsr);
    endtask : rd

    // one-cycle event pulse with the bus idle
    task automatic evt(input logic [15:0] b);
        event_in <= b;
        host_model_inst.idle();
        event_in <= '0;
    endtask : evt

    always @(posedge clk)
    begin
        if (rd_q)
            chk16(rdata, exp_q.pop_front());
        else if (nrst)
            chk16(rdata, 16'h0000);
        rd_q <= rd_stb && ce && nrst;
        cycles <= cycles + 1;
        if (cycles > 2000)
        begin
            err_count++;
            give_verdict();
        end
    end

    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        host_model_inst.idle();
        chk_irq(1'b1);
        rd(ADDR_ENABLE, 16'h0000);
        rd(ADDR_PENDING, 16'h0000);
        rd(ADDR_CONFIG, 16'h2000);
        rd(5'h05, 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            lfsr = next_rand(lfsr);
            wr(ADDR_ENABLE, lfsr);
            rd(ADDR_ENABLE, lfsr & EV);
        end
        wr(ADDR_ENABLE, 16'hFFFF);
        rd(ADDR_ENABLE, EV);
        wr(ADDR_ENABLE, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            inv_polarity <= i[1];
            basic_mode_jabber <= i[0];
            host_model_inst.idle();
            rd(ADDR_STATUS, {14'h0000, i[1], i[0]});
            rd(ADDR_STATUS, {14'h0000, i[1], i[0]});
        end
        lfsr = next_rand(lfsr);
        evt(lfsr);
        wr(ADDR_PENDING, 16'hFFFF);
        rd(ADDR_PENDING, lfsr & EV);
        rd(ADDR_PENDING, 16'h0000);
        host_model_inst.idle();
        chk_irq(1'b1);
        for (int b = 0; b < 16; b++)
        begin
            wr(ADDR_ENABLE, 16'h0001 << b);
            evt(16'h0001 << b);
            @(posedge clk);
            chk_irq(!EV[b]);
            rd(ADDR_PENDING, EV & (16'h0001 << b));
            host_model_inst.idle();
            chk_irq(1'b1);
        end
        // event in the read cycle must survive the clear
        evt(16'h0400);
        host_model_inst.idle();
        event_in <= 16'h0401;
        rd(ADDR_PENDING, 16'h0400);
        event_in <= '0;
        rd(ADDR_PENDING, 16'h0401);
        wr(ADDR_CONFIG, 16'h0000);
        wr(ADDR_ENABLE, 16'h0002);
        evt(16'h0002);
        @(posedge clk);
        chk_irq(1'b1);
        rd(ADDR_CONFIG, 16'h0000);
        rd(ADDR_PENDING, 16'h0002);
        host_model_inst.idle();
        chk_irq(1'b0);
        ce <= 1'b0;
        wr(ADDR_ENABLE, 16'hFFFF);
        ce <= 1'b1;
        rd(ADDR_ENABLE, 16'h0002);
        host_model_inst.idle();
        nrst <= 1'b0;
        host_model_inst.idle();
        nrst <= 1'b1;
        host_model_inst.idle();
        rd(ADDR_ENABLE, 16'h0000);
        rd(ADDR_CONFIG, 16'h2000);
        host_model_inst.idle();
        chk_irq(1'b1);
        host_model_inst.idle();
        give_verdict();
    end
endmodule : tb_top
